/* File: inc/pwb_pkg.sv */
// shared constants for the pixel output white balance stage
package pwb_pkg;
    // data path
    localparam int DATA_W    = 8;
    localparam int LUT_DEPTH = 256;
    localparam int N_COLORS  = 3;

    // page 0 register offsets
    localparam logic [7:0] OSC_CTL_ADDR = 8'h02;
    localparam logic [7:0] OUT_CTL_ADDR = 8'h03;
    localparam logic [7:0] STATUS_ADDR  = 8'h04;
    localparam logic [7:0] WB_CTL_ADDR  = 8'h2A;

    // field positions
    localparam int OSC_EN_BIT    = 5;
    localparam int OSC_SEL_LSB   = 1;
    localparam int EDGE_BIT      = 0;
    localparam int POST_DITH_BIT = 1;
    localparam int PRE_DITH_BIT  = 2;
    localparam int PAGE_LSB      = 6;
    localparam int WB_EN_BIT     = 5;
    localparam int RELOAD_BIT    = 4;

    // page codes
    localparam logic [1:0] PAGE_CFG   = 2'h0;
    localparam logic [1:0] PAGE_RED   = 2'h1;
    localparam logic [1:0] PAGE_GREEN = 2'h2;
    localparam logic [1:0] PAGE_BLUE  = 2'h3;

    // reset values and writable masks
    localparam logic [7:0] WB_CTL_RST   = 8'h00;
    localparam logic [7:0] WB_CTL_MASK  = 8'hF0;
    localparam logic [7:0] OSC_CTL_RST  = 8'h00;
    localparam logic [7:0] OSC_CTL_MASK = 8'h26;
    localparam logic [7:0] OUT_CTL_RST  = 8'h01;
    localparam logic [7:0] OUT_CTL_MASK = 8'h07;

    // bus address, value arbitrary; bit 0 is the page 0 alias
    localparam logic [6:0] I2C_ADDR_DFLT = 7'h2C;

    // fallback oscillator timing
    localparam int CLOCK_HZ     = 10_000_000;
    localparam int OSC_BASE_HZ  = 2_500_000;
    localparam int OSC_HALF_CYC = CLOCK_HZ / (2 * OSC_BASE_HZ);
    localparam int OSC_CNT_W    = 5;
    typedef logic [OSC_CNT_W-1:0] pwb_osc_cnt_t;
endpackage

/* File: rtl/pwb_lut.sv */
// one color table: host write port, pixel and host read ports
`timescale 1ns/1ns
module pwb_lut #(
    parameter int W     = 8,
    parameter int DEPTH = 256,
    localparam int AW   = $clog2(DEPTH)
) (
    // clocking
    input  wire logic          clk,
    input  wire logic          ce,
    // host side
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] host_addr,
    output logic      [W-1:0]  host_data,
    // pixel side
    input  wire logic [AW-1:0] px_addr,
    output logic      [W-1:0]  px_data
);
    // contents are undefined until the host loads them
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // separate read port keeps the pixel stream running during writes
    assign px_data   = mem[px_addr];
    assign host_data = mem[host_addr];

    AST_LUT_STORE: assert property (@(posedge clk) disable iff (!ce)
        we |=> mem[$past(waddr)] == $past(wdata))
        else $error("table entry not stored");
endmodule

/* File: rtl/pwb_i2c_slave.sv */
// i2c slave with register pointer, auto increment and page 0 alias
`timescale 1ns/1ns
module pwb_i2c_slave (
    // clocking
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [6:0] dev_addr,
    // bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_drv,
    // register access
    output logic            wr_stb,
    output logic            cfg_sel,
    output logic [7:0]      reg_addr,
    output logic [7:0]      wr_data,
    input  wire logic [7:0] rd_data
);
    typedef enum logic [3:0] {
        S_IDLE, S_BEGIN, S_ADDR, S_AACK, S_REG, S_RACK,
        S_WR, S_WACK, S_TX, S_MACK
    } pwb_i2c_e;
    // the scl fall right after a start carries no bit, so it is skipped
    pwb_i2c_e   st;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       rw;
    logic       nack;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;

    // stage 0 feeds only stage 1
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else if (ce) begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end

    assign scl_rise = scl_s[1] && !scl_s[2];
    assign scl_fall = !scl_s[1] && scl_s[2];
    assign start    = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
    assign stop     = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st       <= S_IDLE;
            cnt      <= 3'h0;
            sh       <= 8'h00;
            tx       <= 8'h00;
            rw       <= 1'b0;
            nack     <= 1'b0;
            sda_drv  <= 1'b0;
            wr_stb   <= 1'b0;
            cfg_sel  <= 1'b0;
            reg_addr <= 8'h00;
            wr_data  <= 8'h00;
        end else if (ce) begin
            wr_stb <= 1'b0;
            if (start) begin
                st      <= S_BEGIN;
                cnt     <= 3'h0;
                sda_drv <= 1'b0;
            end else if (stop) begin
                st      <= S_IDLE;
                sda_drv <= 1'b0;
            end else if (scl_rise) begin
                sh <= {sh[6:0], sda_s[1]};
                if (st == S_MACK) begin
                    nack     <= sda_s[1];
                    reg_addr <= reg_addr + 8'h01;
                end
            end else if (scl_fall) begin
                cnt <= cnt + 3'h1;
                unique case (st)
                    S_IDLE: cnt <= 3'h0;
                    S_BEGIN: begin
                        cnt <= 3'h0;
                        st  <= S_ADDR;
                    end
                    S_ADDR: if (cnt == 3'h7) begin
                        if (sh[7:2] == dev_addr[6:1]) begin
                            st      <= S_AACK;
                            sda_drv <= 1'b1;
                            rw      <= sh[0];
                            cfg_sel <= sh[1];
                        end else begin
                            st <= S_IDLE;
                        end
                    end
                    S_AACK: begin
                        cnt <= 3'h0;
                        if (rw) begin
                            st      <= S_TX;
                            tx      <= rd_data;
                            sda_drv <= !rd_data[7];
                        end else begin
                            st      <= S_REG;
                            sda_drv <= 1'b0;
                        end
                    end
                    S_REG: if (cnt == 3'h7) begin
                        reg_addr <= sh;
                        sda_drv  <= 1'b1;
                        st       <= S_RACK;
                    end
                    S_RACK: begin
                        cnt     <= 3'h0;
                        sda_drv <= 1'b0;
                        st      <= S_WR;
                    end
                    S_WR: if (cnt == 3'h7) begin
                        wr_data <= sh;
                        wr_stb  <= 1'b1;
                        sda_drv <= 1'b1;
                        st      <= S_WACK;
                    end
                    S_WACK: begin
                        cnt      <= 3'h0;
                        sda_drv  <= 1'b0;
                        reg_addr <= reg_addr + 8'h01;
                        st       <= S_WR;
                    end
                    S_TX: if (cnt == 3'h7) begin
                        sda_drv <= 1'b0;
                        st      <= S_MACK;
                    end else begin
                        tx      <= {tx[6:0], 1'b0};
                        sda_drv <= !tx[6];
                    end
                    S_MACK: begin
                        cnt <= 3'h0;
                        if (nack) begin
                            st <= S_IDLE;
                        end else begin
                            st      <= S_TX;
                            tx      <= rd_data;
                            sda_drv <= !rd_data[7];
                        end
                    end
                endcase
            end
        end
    end

    AST_I2C_ADDR_ACK: assert property (@(posedge clk)
        disable iff (!rst_n || !ce)
        (st == S_ADDR && scl_fall && cnt == 3'h7 && !start && !stop
         && sh[7:2] == dev_addr[6:1]) |=> sda_drv && st == S_AACK)
        else $error("address match not acknowledged");
endmodule

/* File: rtl/pwb_output_stage.sv */
// pixel output stage: white balance tables, strobe edge, fallback clock
`timescale 1ns/1ns
module pwb_output_stage #(
    parameter logic [6:0] I2C_ADDR = pwb_pkg::I2C_ADDR_DFLT
) (
    // clock, reset, enable
    input  wire logic                      CLOCK,
    input  wire logic                      RST_N,
    input  wire logic                      CE,
    // i2c pins
    input  wire logic                      SCL_IN,
    input  wire logic                      SDA_IN,
    output logic                           SDA_OUT,
    output logic                           SDA_OE_N,
    // recovered link
    input  wire logic                      LINK_LOST,
    input  wire logic [pwb_pkg::DATA_W-1:0] R_IN,
    input  wire logic [pwb_pkg::DATA_W-1:0] G_IN,
    input  wire logic [pwb_pkg::DATA_W-1:0] B_IN,
    // panel side
    output logic                           PCLK_OUT,
    output logic      [pwb_pkg::DATA_W-1:0] R_OUT,
    output logic      [pwb_pkg::DATA_W-1:0] G_OUT,
    output logic      [pwb_pkg::DATA_W-1:0] B_OUT,
    // dithering stage controls
    output logic                           POST_DITHER_EN,
    output logic                           PRE_DITHER_EN
);
    import pwb_pkg::*;

    logic [7:0]        wb_ctl;
    logic [7:0]        osc_ctl;
    logic [7:0]        out_ctl;
    logic              init_done;
    logic              wr_stb;
    logic              cfg_sel;
    logic              sda_drv;
    logic [7:0]        reg_addr;
    logic [7:0]        wr_data;
    logic [7:0]        rd_data;
    logic [1:0]        page;
    logic [1:0]        eff_page;
    logic              wb_en;
    logic              reload_en;
    logic              tab_wr_ok;
    logic              cfg_wr;
    logic              osc_en;
    logic [1:0]        osc_sel;
    logic              edge_sel;
    logic              fb_run;
    logic              osc_tick;
    logic              pclk_q;
    logic              launch;
    pwb_osc_cnt_t      osc_cnt;
    pwb_osc_cnt_t      osc_lim;
    logic [N_COLORS-1:0] tab_we;
    logic [DATA_W-1:0] pix_in  [N_COLORS];
    logic [DATA_W-1:0] pix_out [N_COLORS];
    logic [DATA_W-1:0] px_rd   [N_COLORS];
    logic [DATA_W-1:0] host_rd [N_COLORS];

    pwb_i2c_slave u_i2c (
        .clk      (CLOCK),
        .rst_n    (RST_N),
        .ce       (CE),
        .dev_addr (I2C_ADDR),
        .scl_in   (SCL_IN),
        .sda_in   (SDA_IN),
        .sda_drv  (sda_drv),
        .wr_stb   (wr_stb),
        .cfg_sel  (cfg_sel),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .rd_data  (rd_data)
    );

    // open drain: only ever pull low
    assign SDA_OUT  = 1'b0;
    assign SDA_OE_N = !sda_drv;

    // control fields
    assign page      = wb_ctl[PAGE_LSB +: 2];
    assign wb_en     = wb_ctl[WB_EN_BIT];
    assign reload_en = wb_ctl[RELOAD_BIT];
    assign osc_en    = osc_ctl[OSC_EN_BIT];
    assign osc_sel   = osc_ctl[OSC_SEL_LSB +: 2];
    assign edge_sel  = out_ctl[EDGE_BIT];
    assign POST_DITHER_EN = out_ctl[POST_DITH_BIT];
    assign PRE_DITHER_EN  = out_ctl[PRE_DITH_BIT];

    // the alias address always reaches page 0, so a host stuck on a
    // table page can still get back to the control register
    assign eff_page = cfg_sel ? PAGE_CFG : page;
    assign cfg_wr   = wr_stb && eff_page == PAGE_CFG;

    // after the first enable, tables are frozen unless reload is set
    assign tab_wr_ok = !init_done || reload_en;

    // control register writes
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            wb_ctl <= WB_CTL_RST;
        end else if (CE && cfg_wr && reg_addr == WB_CTL_ADDR) begin
            wb_ctl <= wr_data & WB_CTL_MASK;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            osc_ctl <= OSC_CTL_RST;
        end else if (CE && cfg_wr && reg_addr == OSC_CTL_ADDR) begin
            osc_ctl <= wr_data & OSC_CTL_MASK;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            out_ctl <= OUT_CTL_RST;
        end else if (CE && cfg_wr && reg_addr == OUT_CTL_ADDR) begin
            out_ctl <= wr_data & OUT_CTL_MASK;
        end
    end

    // initial load ends when the host first turns white balance on
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            init_done <= 1'b0;
        end else if (CE && cfg_wr && reg_addr == WB_CTL_ADDR
                     && wr_data[WB_EN_BIT]) begin
            init_done <= 1'b1;
        end
    end

    // host read mux
    always_comb begin
        rd_data = 8'h00;
        unique case (eff_page)
            PAGE_CFG: begin
                unique case (reg_addr)
                    OSC_CTL_ADDR: rd_data = osc_ctl;
                    OUT_CTL_ADDR: rd_data = out_ctl;
                    STATUS_ADDR:  rd_data = {5'h00, fb_run,
                                             LINK_LOST, init_done};
                    WB_CTL_ADDR:  rd_data = wb_ctl & WB_CTL_MASK;
                    default:      rd_data = 8'h00;
                endcase
            end
            PAGE_RED:   rd_data = host_rd[0];
            PAGE_GREEN: rd_data = host_rd[1];
            PAGE_BLUE:  rd_data = host_rd[2];
        endcase
    end

    // fallback oscillator, divided from the local clock
    assign fb_run  = LINK_LOST && osc_en;
    assign osc_lim = pwb_osc_cnt_t'((OSC_HALF_CYC << osc_sel) - 1);
    // >= so a faster select never strands the count above its new limit
    assign osc_tick = osc_cnt >= osc_lim;

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            osc_cnt <= '0;
        end else if (CE) begin
            if (!fb_run || osc_tick) begin
                osc_cnt <= '0;
            end else begin
                osc_cnt <= osc_cnt + pwb_osc_cnt_t'(1);
            end
        end
    end

    // pixel clock: half the local rate while locked, oscillator when
    // lost and enabled, held low otherwise
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pclk_q <= 1'b0;
        end else if (CE) begin
            if (!LINK_LOST) begin
                pclk_q <= !pclk_q;
            end else if (fb_run) begin
                if (osc_tick) begin
                    pclk_q <= !pclk_q;
                end
            end else begin
                pclk_q <= 1'b0;
            end
        end
    end

    assign PCLK_OUT = pclk_q;

    // data changes on the edge opposite to the strobe edge, giving a
    // full local cycle of setup and hold around the strobe
    assign launch = !LINK_LOST && pclk_q == edge_sel;

    assign pix_in[0] = R_IN;
    assign pix_in[1] = G_IN;
    assign pix_in[2] = B_IN;

    // the pointer byte of a transfer never strobes, so only data lands
    for (genvar c = 0; c < N_COLORS; c++) begin : g_color
        assign tab_we[c] = wr_stb && tab_wr_ok
                           && eff_page == 2'(c + 1);

        pwb_lut #(
            .W     (DATA_W),
            .DEPTH (LUT_DEPTH)
        ) u_lut (
            .clk       (CLOCK),
            .ce        (CE),
            .we        (tab_we[c]),
            .waddr     (reg_addr),
            .wdata     (wr_data),
            .host_addr (reg_addr),
            .host_data (host_rd[c]),
            .px_addr   (pix_in[c]),
            .px_data   (px_rd[c])
        );

        always_ff @(posedge CLOCK) begin
            if (!RST_N) begin
                pix_out[c] <= '0;
            end else if (CE) begin
                if (LINK_LOST) begin
                    pix_out[c] <= '0;
                end else if (launch) begin
                    pix_out[c] <= wb_en ? px_rd[c] : pix_in[c];
                end
            end
        end
    end

    // full 8-bit result goes on; the dither stage narrows it if enabled
    assign R_OUT = pix_out[0];
    assign G_OUT = pix_out[1];
    assign B_OUT = pix_out[2];

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N || !CE);
    // frozen cycles disable an attempt; a $past across them is guarded

    AST_FALLBACK_STOP: assert property (
        LINK_LOST && !osc_en |=> !PCLK_OUT)
        else $error("pixel clock runs with oscillator disabled");

    AST_FALLBACK_RUN: assert property (
        fb_run && osc_tick |=> PCLK_OUT != $past(PCLK_OUT))
        else $error("fallback clock did not toggle");

    AST_OSC_RATE: assert property (
        (fb_run && osc_sel == 2'h0)[*3] ##0 osc_tick
        |-> $past(osc_tick, 2) && !$past(osc_tick))
        else $error("fallback half period wrong");

    AST_EDGE_RISE: assert property (
        edge_sel && !LINK_LOST
        && $past(edge_sel && launch && CE && !LINK_LOST)
        |-> !PCLK_OUT ##1 PCLK_OUT)
        else $error("data not launched ahead of rising edge");

    AST_EDGE_FALL: assert property (
        !edge_sel && !LINK_LOST
        && $past(!edge_sel && launch && CE && !LINK_LOST)
        |-> PCLK_OUT ##1 !PCLK_OUT)
        else $error("data not launched ahead of falling edge");

    AST_LUT_PATH: assert property (
        launch && wb_en |=> R_OUT == $past(px_rd[0]))
        else $error("red output is not the table entry");

    AST_BYPASS: assert property (
        launch && !wb_en |=> G_OUT == $past(G_IN))
        else $error("bypass altered green data");

    AST_LOCKED: assert property (
        wr_stb && eff_page != PAGE_CFG && init_done && !reload_en
        |-> tab_we == '0)
        else $error("table written while locked");

    AST_RELOAD: assert property (
        wr_stb && eff_page == PAGE_BLUE && reload_en
        |-> tab_we == 3'h4 ##1 host_rd[2] == $past(wr_data))
        else $error("reload write to blue table refused");

    AST_PAGE: assert property (
        cfg_wr && reg_addr == WB_CTL_ADDR
        |=> page == $past(wr_data[7:6]))
        else $error("page field not updated");

    AST_RSVD: assert property (
        eff_page == PAGE_CFG && reg_addr == WB_CTL_ADDR
        |-> rd_data[3:0] == 4'h0)
        else $error("reserved control bits read nonzero");

    AST_LOCK_CLOCK: assert property (
        !LINK_LOST |=> PCLK_OUT != $past(PCLK_OUT))
        else $error("locked pixel clock did not toggle");

    AST_HOLD: assert property (
        !launch && !LINK_LOST |=> $stable(R_OUT) && $stable(B_OUT))
        else $error("pixel data moved outside its launch cycle");

    AST_LOST_BLANK: assert property (
        LINK_LOST |=> R_OUT == '0 && G_OUT == '0 && B_OUT == '0)
        else $error("pixel data not blanked while link is lost");

    AST_INIT_STICKY: assert property (
        init_done |=> init_done)
        else $error("initial load flag cleared");

    AST_CFG_ONLY: assert property (
        cfg_wr |-> tab_we == '0)
        else $error("control write reached a table");

    AST_POST_DITHER: assert property (
        cfg_wr && reg_addr == OUT_CTL_ADDR
        |=> POST_DITHER_EN == $past(wr_data[POST_DITH_BIT]))
        else $error("post table dither enable not updated");

    COV_FALLBACK: cover property (fb_run && osc_tick);
    COV_RELOAD: cover property (init_done && reload_en && |tab_we);
    COV_LUT_RISE: cover property (launch && wb_en && edge_sel);
    COV_LUT_FALL: cover property (launch && wb_en && !edge_sel);
    COV_SLOW_OSC: cover property (fb_run && osc_sel == 2'h3 && osc_tick);
endmodule

/* File: verif/pwb_i2c_host.sv */
// i2c host model for the serial control pins
`timescale 1ns/1ns
module pwb_i2c_host (
    // clock reference
    input  wire logic clk,
    // bus pins
    input  wire logic sda,
    output logic      scl,
    output logic      sda_rel
);
    int nacks = 0;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // changes follow falling clock edges so the device never samples a race
    task automatic bit_io(input logic b, output logic s);
        @(negedge clk);
        scl = 1'b0;
        #200 sda_rel = b;
        #200 scl = 1'b1;
        #300 s = sda;
        #100;
    endtask
    // scl is lowered first so a pending ack is dropped before sda rises
    task automatic start;
        @(negedge clk);
        scl = 1'b0;
        #200 sda_rel = 1'b1;
        #200 scl = 1'b1;
        #400 sda_rel = 1'b0;
        #400;
    endtask
    task automatic stop;
        @(negedge clk);
        scl = 1'b0;
        #200 sda_rel = 1'b0;
        #200 scl = 1'b1;
        #400 sda_rel = 1'b1;
        #400;
    endtask
    task automatic wbyte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        if (s !== 1'b0) nacks++;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask
endmodule

/* File: verif/pwb_output_stage_bench.sv */
// self-checking bench for the pixel output stage
`timescale 1ns/1ns
module pwb_output_stage_bench;
    import pwb_pkg::*;
    localparam logic [6:0] DEV = I2C_ADDR_DFLT;
    localparam logic [6:0] CFG = I2C_ADDR_DFLT | 7'h01;
    logic       CLOCK = 1'b0;
    logic       RST_N = 1'b0;
    logic       CE = 1'b1;
    logic       LINK_LOST = 1'b0;
    logic [7:0] R_IN = 8'h00;
    logic [7:0] G_IN = 8'h00;
    logic [7:0] B_IN = 8'h00;
    wire logic  SCL_IN, SDA_IN, SDA_OUT, SDA_OE_N, sda_rel, PCLK_OUT;
    wire logic  POST_DITHER_EN, PRE_DITHER_EN;
    wire logic [7:0] R_OUT, G_OUT, B_OUT;
    int         failures = 0;
    int         total_checks = 0;
    int         n;
    logic [7:0] rd;

    always #50 CLOCK = ~CLOCK;
    // open drain line with pull-up
    assign SDA_IN = sda_rel & (SDA_OE_N | SDA_OUT);

    pwb_output_stage DUT (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE),
        .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
        .SDA_OE_N(SDA_OE_N), .LINK_LOST(LINK_LOST), .R_IN(R_IN),
        .G_IN(G_IN), .B_IN(B_IN), .PCLK_OUT(PCLK_OUT), .R_OUT(R_OUT),
        .G_OUT(G_OUT), .B_OUT(B_OUT), .POST_DITHER_EN(POST_DITHER_EN),
        .PRE_DITHER_EN(PRE_DITHER_EN));
    pwb_i2c_host host (.clk(CLOCK), .sda(SDA_IN), .scl(SCL_IN),
        .sda_rel(sda_rel));

    task end_of_test;
        if (failures == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task reg_wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
        host.start;
        host.wbyte({a, 1'b0});
        host.wbyte(p);
        host.wbyte(d);
        host.stop;
    endtask
    task reg_rd(input logic [6:0] a, input logic [7:0] p,
                output logic [7:0] d);
        host.start;
        host.wbyte({a, 1'b0});
        host.wbyte(p);
        host.start;
        host.wbyte({a, 1'b1});
        host.rbyte(1'b1, d);
        host.stop;
    endtask
    function automatic logic [7:0] lut_val(input int c, input logic [7:0] i);
        case (c)
            0: return ~i;
            1: return i ^ 8'h5A;
            default: return i + 8'h07;
        endcase
    endfunction
    task px(input logic [7:0] v, input logic [7:0] er, input logic [7:0] eg,
            input logic [7:0] eb);
        @(negedge CLOCK);
        R_IN = v;
        G_IN = v;
        B_IN = v;
        repeat (4) @(negedge CLOCK);
        chk(R_OUT, er);
        chk(G_OUT, eg);
        chk(B_OUT, eb);
    endtask
    task wait_tog(output int k);
        logic p;
        p = PCLK_OUT;
        k = 0;
        while (PCLK_OUT === p && k < 64) begin
            @(negedge CLOCK);
            k++;
        end
        if (k == 64) begin
            failures++;
            end_of_test;
        end
    endtask

    initial begin
        repeat (16) @(negedge CLOCK);
        RST_N = 1'b1;
        repeat (3) @(negedge CLOCK);
        reg_rd(CFG, WB_CTL_ADDR, rd);
        chk(rd, WB_CTL_RST);
        reg_rd(CFG, OSC_CTL_ADDR, rd);
        chk(rd, OSC_CTL_RST);
        reg_rd(CFG, OUT_CTL_ADDR, rd);
        chk(rd, OUT_CTL_RST);
        reg_wr(CFG, WB_CTL_ADDR, 8'h0F);
        reg_rd(CFG, WB_CTL_ADDR, rd);
        chk(rd, 8'h00);
        px(8'h3C, 8'h3C, 8'h3C, 8'h3C);
        for (int c = 0; c < 3; c++) begin
            reg_wr(CFG, WB_CTL_ADDR, {2'(c + 1), 6'h00});
            host.start;
            host.wbyte({DEV, 1'b0});
            host.wbyte(8'h00);
            for (int i = 0; i < 256; i++)
                host.wbyte(lut_val(c, 8'(i)));
            host.stop;
        end
        reg_wr(CFG, WB_CTL_ADDR, 8'h20);
        for (int v = 0; v < 256; v += 85)
            px(8'(v), lut_val(0, 8'(v)), lut_val(1, 8'(v)),
               lut_val(2, 8'(v)));
        for (int c = 0; c < 3; c++) begin
            reg_wr(CFG, WB_CTL_ADDR, {2'(c + 1), 6'h20});
            reg_rd(DEV, 8'hFF, rd);
            chk(rd, lut_val(c, 8'hFF));
        end
        reg_wr(DEV, 8'h05, 8'h00);
        reg_rd(DEV, 8'h05, rd);
        chk(rd, lut_val(2, 8'h05));
        reg_wr(CFG, WB_CTL_ADDR, 8'hF0);
        reg_wr(DEV, 8'h05, 8'h14);
        reg_rd(DEV, 8'h05, rd);
        chk(rd, 8'h14);
        px(8'h05, lut_val(0, 8'h05), lut_val(1, 8'h05), 8'h14);
        for (int e = 0; e < 2; e++) begin
            reg_wr(CFG, OUT_CTL_ADDR, 8'(6 + e));
            chk({6'h0, PRE_DITHER_EN, POST_DITHER_EN}, 8'h03);
            rd = R_OUT;
            repeat (16) begin
                @(negedge CLOCK);
                if (R_OUT !== rd)
                    chk({7'h0, PCLK_OUT}, {7'h0, e == 0});
                rd = R_OUT;
                R_IN = R_IN + 8'h01;
            end
        end
        CE = 1'b0;
        rd = {7'h0, PCLK_OUT};
        repeat (3) @(negedge CLOCK);
        chk({7'h0, PCLK_OUT}, rd); // enable low freezes the pixel clock
        CE = 1'b1;
        LINK_LOST = 1'b1;
        repeat (4) @(negedge CLOCK);
        chk({7'h0, PCLK_OUT}, 8'h00);
        chk(R_OUT, 8'h00);
        for (int s = 0; s < 4; s++) begin
            reg_wr(CFG, OSC_CTL_ADDR, 8'(32 + 2 * s));
            wait_tog(n);
            wait_tog(n);
            chk(8'(n), 8'(2 << s));
        end
        reg_rd(CFG, STATUS_ADDR, rd);
        chk(rd, 8'h07);
        chk(8'(host.nacks), 8'h00);
        end_of_test;
    end
endmodule
